// ===== common/aes_params.svh
// Constants of the AES-128 engine: offsets, fields, reset values, timing
`ifndef AES_PARAMS_SVH
`define AES_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AES_OFS_CTRL      2'h0
`define AES_OFS_STATUS    2'h1
`define AES_OFS_STATE     2'h2
`define AES_OFS_KEY       2'h3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AES_CTRL_REQ_BIT  7
`define AES_CTRL_MODE_BIT 5
`define AES_CTRL_DIR_BIT  3
`define AES_CTRL_IM_BIT   2
`define AES_STAT_ERR_BIT  7
`define AES_STAT_DONE_BIT 0

// ----------------------------------------------------------------
// Reset values and cipher constants
// ----------------------------------------------------------------
`define AES_BYTE_ZERO     8'h00
`define AES_BLOCK_ZERO    128'h0
`define AES_CNT_ZERO      4'h0
`define AES_CNT_LAST      4'hF
`define AES_RND_FIRST     4'h1
`define AES_RND_LAST      4'hA
`define AES_RCON_FIRST    8'h01
`define AES_RCON_LAST     8'h36
`define AES_GF_POLY       8'h1B
`define AES_AFFINE_C      8'h63
`define AES_AFFINE_INV_C  8'h05

// ----------------------------------------------------------------
// Timing: a run must finish within this time
// ----------------------------------------------------------------
`define AES_RUN_TIME_NS   24000
`define AES_CLK_PERIOD_NS 20
`define AES_RUN_CYCLES    (`AES_RUN_TIME_NS / `AES_CLK_PERIOD_NS)

`endif

// ===== common/aes_pkg.sv
// Types shared by the AES-128 engine
package aes_pkg;

  typedef enum logic {
    AES_IDLE,
    AES_RUN
  } aes_state_t;

  typedef logic [127:0] aes_block_t;

endpackage

// ===== rtl/aes_engine.sv
// AES-128 engine with byte-wide key and data buffer ports
//
// Operation
// - AES-128 cipher on 128-bit blocks and keys
// - ECB both directions, CBC encrypt only
// - Core runs on the crystal clock domain
// - Runs independently of radio traffic
// - Transceiver sleep clears all engine registers
// - Each buffer access advances byte counter
// - Starting a run rewinds byte counters
// - Partial buffer access makes run error
// - Interrupt only when enable bit set
// - Writing request bit starts a run
// - Run completes within 24 microseconds
// - Result read as sixteen data bytes
// - Status read clears error flag
// - Data port access clears done flag
// - CBC XORs previous output into input
// - Key port reads last round key after an encrypt run, the initial key after a decrypt run
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "aes_params.svh"

module aes_engine
(
  // Clock and reset (core_clk stands in for the crystal clock)
  // crystal clock domain
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Transceiver sleep state
  input  wire logic       trx_sleep,
  // Register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Status outputs
  output logic            busy,
  output logic            completion_irq
);

  // ----------------------------------------------------------------
  // Byte and field helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] get_byte(input aes_pkg::aes_block_t v,
                                          input logic [3:0] i);
    get_byte = v[8'd127 - {i, 3'b000} -: 8];
  endfunction

  function automatic logic [7:0] xt(input logic [7:0] a);
    xt = {a[6:0], 1'b0} ^ (a[7] ? `AES_GF_POLY : `AES_BYTE_ZERO);
  endfunction

  // Inverse of xt, used to walk the round constant backwards
  function automatic logic [7:0] xt_inv(input logic [7:0] a);
    logic [7:0] poly;
    poly   = `AES_GF_POLY;
    xt_inv = a[0] ? {1'b1, a[7:1] ^ poly[7:1]} : {1'b0, a[7:1]};
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = `AES_BYTE_ZERO;
    x = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        p = p ^ x;
      x = xt(x);
    end
    gmul = p;
  endfunction

  // Field inverse as a^254; zero maps to zero
  function automatic logic [7:0] gf_inv(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h01;
    p = gmul(a, a);
    for (int i = 1; i < 8; i++)
    begin
      r = gmul(r, p);
      p = gmul(p, p);
    end
    gf_inv = r;
  endfunction

  function automatic logic [7:0] rotl(input logic [7:0] a,
                                      input int n);
    rotl = (a << n) | (a >> (8 - n));
  endfunction

  // Computed substitution keeps the file free of large tables
  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] b;
    b = gf_inv(a);
    sbox = b ^ rotl(b, 1) ^ rotl(b, 2) ^ rotl(b, 3) ^ rotl(b, 4)
         ^ `AES_AFFINE_C;
  endfunction

  function automatic logic [7:0] sbox_inv(input logic [7:0] a);
    sbox_inv = gf_inv(rotl(a, 1) ^ rotl(a, 3) ^ rotl(a, 6)
                      ^ `AES_AFFINE_INV_C);
  endfunction

  // ----------------------------------------------------------------
  // Round transforms; byte index is column * 4 + row
  // ----------------------------------------------------------------
  function automatic aes_pkg::aes_block_t sub_shift(
    input aes_pkg::aes_block_t s, input logic inv);
    aes_pkg::aes_block_t o;
    logic [3:0]          src;
    o = `AES_BLOCK_ZERO;
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
      begin
        src = inv ? 4'(((c - r + 4) % 4) * 4 + r)
                  : 4'(((c + r) % 4) * 4 + r);
        o[127 - 8 * (c * 4 + r) -: 8] = inv ? sbox_inv(get_byte(s, src))
                                            : sbox(get_byte(s, src));
      end
    sub_shift = o;
  endfunction

  function automatic aes_pkg::aes_block_t mix(
    input aes_pkg::aes_block_t s, input logic inv);
    aes_pkg::aes_block_t o;
    logic [7:0]          cf [4];
    logic [7:0]          acc;
    o = `AES_BLOCK_ZERO;
    cf[0] = inv ? 8'h0E : 8'h02;
    cf[1] = inv ? 8'h0B : 8'h03;
    cf[2] = inv ? 8'h0D : 8'h01;
    cf[3] = inv ? 8'h09 : 8'h01;
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
      begin
        acc = `AES_BYTE_ZERO;
        for (int j = 0; j < 4; j++)
          acc = acc ^ gmul(cf[(j - r + 4) % 4], get_byte(s, 4'(c * 4 + j)));
        o[127 - 8 * (c * 4 + r) -: 8] = acc;
      end
    mix = o;
  endfunction

  function automatic logic [31:0] sub_rot(input logic [31:0] w);
    sub_rot = {sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0]),
               sbox(w[31:24])};
  endfunction

  // Next round key from the current one
  function automatic aes_pkg::aes_block_t key_fwd(
    input aes_pkg::aes_block_t k, input logic [7:0] rc);
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    w0 = k[127:96] ^ sub_rot(k[31:0]) ^ {rc, 24'h0};
    w1 = k[95:64] ^ w0;
    w2 = k[63:32] ^ w1;
    w3 = k[31:0] ^ w2;
    key_fwd = {w0, w1, w2, w3};
  endfunction

  // Previous round key from the current one
  function automatic aes_pkg::aes_block_t key_bwd(
    input aes_pkg::aes_block_t k, input logic [7:0] rc);
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    w3 = k[31:0] ^ k[63:32];
    w2 = k[63:32] ^ k[95:64];
    w1 = k[95:64] ^ k[127:96];
    key_bwd = {k[127:96] ^ sub_rot(w3) ^ {rc, 24'h0}, w1, w2, w3};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  aes_pkg::aes_state_t state_r;
  aes_pkg::aes_block_t key_r;     // Key as written, reused every run
  aes_pkg::aes_block_t rkey_r;    // Working round key
  aes_pkg::aes_block_t data_r;    // Data buffer
  aes_pkg::aes_block_t chain_r;   // Last cipher output for chaining
  aes_pkg::aes_block_t st_r;      // Cipher state during a run
  aes_pkg::aes_block_t st_nxt;
  aes_pkg::aes_block_t rkey_nxt;
  logic [7:0]          rcon_r;
  logic [3:0]          round_r;
  logic [3:0]          kcnt_r;
  logic [3:0]          dcnt_r;
  logic                mode_cbc_r;
  logic                dir_dec_r;
  logic                completion_irq_enable;
  logic                done_r;
  logic                run_error_flag;
  logic                err_pend_r;

  // Decoded accesses, ignored while asleep
  logic acc_ok;
  logic key_acc;
  logic data_acc;
  logic start;
  logic last_rnd;

  assign acc_ok   = !trx_sleep;
  assign key_acc  = acc_ok && (reg_wr || reg_rd)
                    && reg_addr == `AES_OFS_KEY && state_r == aes_pkg::AES_IDLE;
  assign data_acc = acc_ok && (reg_wr || reg_rd)
                    && reg_addr == `AES_OFS_STATE
                    && state_r == aes_pkg::AES_IDLE;
  assign start    = acc_ok && reg_wr && reg_addr == `AES_OFS_CTRL
                    && reg_wdata[`AES_CTRL_REQ_BIT]
                    && state_r == aes_pkg::AES_IDLE;
  assign last_rnd = round_r == `AES_RND_LAST;

  // ----------------------------------------------------------------
  // One cipher round per clock, ten rounds well inside the time budget
  // ----------------------------------------------------------------
  always_comb
  begin
    if (!dir_dec_r)
    begin
      rkey_nxt = key_fwd(rkey_r, rcon_r);
      st_nxt   = sub_shift(st_r, 1'b0);
      if (!last_rnd)
        st_nxt = mix(st_nxt, 1'b0);
      st_nxt = st_nxt ^ rkey_nxt;
    end
    else
    begin
      rkey_nxt = key_bwd(rkey_r, rcon_r);
      st_nxt   = sub_shift(st_r, 1'b1) ^ rkey_nxt;
      if (!last_rnd)
        st_nxt = mix(st_nxt, 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Run sequencing
  // ----------------------------------------------------------------
  // done after ten cycles
  always_ff @(posedge core_clk)
  begin
    if (rst || trx_sleep)
    begin
      state_r <= aes_pkg::AES_IDLE;
      round_r <= `AES_CNT_ZERO;
      rcon_r  <= `AES_BYTE_ZERO;
      st_r    <= `AES_BLOCK_ZERO;
      chain_r <= `AES_BLOCK_ZERO;
    end
    else if (start)
    begin
      state_r <= aes_pkg::AES_RUN;
      round_r <= `AES_RND_FIRST;
      rcon_r  <= reg_wdata[`AES_CTRL_DIR_BIT] ? `AES_RCON_LAST
                                              : `AES_RCON_FIRST;
      st_r    <= data_r ^ key_r
                 ^ (reg_wdata[`AES_CTRL_MODE_BIT] ? chain_r : `AES_BLOCK_ZERO);
    end
    else if (state_r == aes_pkg::AES_RUN)
    begin
      st_r    <= st_nxt;
      round_r <= round_r + 4'h1;
      rcon_r  <= dir_dec_r ? xt_inv(rcon_r) : xt(rcon_r);
      if (last_rnd)
      begin
        state_r <= aes_pkg::AES_IDLE;
        chain_r <= st_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst || trx_sleep)
    begin
      mode_cbc_r            <= 1'b0;
      dir_dec_r             <= 1'b0;
      completion_irq_enable <= 1'b0;
    end
    else if (acc_ok && reg_wr && reg_addr == `AES_OFS_CTRL
             && state_r == aes_pkg::AES_IDLE)
    begin
      mode_cbc_r            <= reg_wdata[`AES_CTRL_MODE_BIT];
      dir_dec_r             <= reg_wdata[`AES_CTRL_DIR_BIT];
      completion_irq_enable <= reg_wdata[`AES_CTRL_IM_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Key buffer and round key
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst || trx_sleep)
    begin
      key_r  <= `AES_BLOCK_ZERO;
      rkey_r <= `AES_BLOCK_ZERO;
    end
    else if (start)
      rkey_r <= key_r;
    else if (state_r == aes_pkg::AES_RUN)
      rkey_r <= rkey_nxt;
    else if (key_acc && reg_wr)
    begin
      key_r[8'd127 - {kcnt_r, 3'b000} -: 8]  <= reg_wdata;
      rkey_r[8'd127 - {kcnt_r, 3'b000} -: 8] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Data buffer: loaded by software, overwritten by the result
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst || trx_sleep)
      data_r <= `AES_BLOCK_ZERO;
    else if (state_r == aes_pkg::AES_RUN && last_rnd)
      data_r <= st_nxt;
    else if (data_acc && reg_wr)
      data_r[8'd127 - {dcnt_r, 3'b000} -: 8] <= reg_wdata;
  end

  // ----------------------------------------------------------------
  // Byte counters; a control read also rewinds them after an
  // interrupted transfer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst || trx_sleep)
    begin
      kcnt_r <= `AES_CNT_ZERO;
      dcnt_r <= `AES_CNT_ZERO;
    end
    else if (start || (acc_ok && reg_rd && reg_addr == `AES_OFS_CTRL))
    begin
      kcnt_r <= `AES_CNT_ZERO;
      dcnt_r <= `AES_CNT_ZERO;
    end
    else
    begin
      if (key_acc)
        kcnt_r <= kcnt_r + 4'h1;
      if (data_acc)
        dcnt_r <= dcnt_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Completion flags; a set in the same cycle as a clear wins
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst || trx_sleep)
    begin
      done_r         <= 1'b0;
      run_error_flag <= 1'b0;
      err_pend_r     <= 1'b0;
    end
    else
    begin
      if (start)
        err_pend_r <= kcnt_r != `AES_CNT_ZERO || dcnt_r != `AES_CNT_ZERO
                      || (reg_wdata[`AES_CTRL_MODE_BIT]
                          && reg_wdata[`AES_CTRL_DIR_BIT]);
      if (acc_ok && reg_rd && reg_addr == `AES_OFS_STATUS)
        run_error_flag <= 1'b0;
      if (data_acc)
        done_r <= 1'b0;
      if (state_r == aes_pkg::AES_RUN && last_rnd)
      begin
        done_r         <= !err_pend_r;
        run_error_flag <= err_pend_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data, busy and interrupt, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst || trx_sleep || !reg_rd)
      reg_rdata <= `AES_BYTE_ZERO;
    else
    begin
      unique case (reg_addr)
        `AES_OFS_CTRL:
          reg_rdata <= {1'b0, 1'b0, mode_cbc_r, 1'b0, dir_dec_r,
                        completion_irq_enable, 2'b00};
        `AES_OFS_STATUS:
          reg_rdata <= {run_error_flag, 6'h00, done_r};
        `AES_OFS_STATE:
          reg_rdata <= data_acc ? get_byte(data_r, dcnt_r) : `AES_BYTE_ZERO;
        `AES_OFS_KEY:
          reg_rdata <= key_acc ? get_byte(rkey_r, kcnt_r) : `AES_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || trx_sleep)
    begin
      busy           <= 1'b0;
      completion_irq <= 1'b0;
    end
    else
    begin
      busy           <= start || (state_r == aes_pkg::AES_RUN && !last_rnd);
      completion_irq <= completion_irq_enable
                        && (done_r || run_error_flag);
    end
  end

endmodule

// ===== verif/aes_engine_properties.sv
// Concurrent checks on the AES engine register port and status outputs
`timescale 1ns/1ps
`include "aes_params.svh"

module aes_engine_chk
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Sleep and register port
  input wire logic       trx_sleep,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Status outputs
  input wire logic       busy,
  input wire logic       completion_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  localparam logic [3:0] RUN_LEN = 4'hA;

  logic       ctl_wr;
  logic       start_req;
  logic       im_q;
  logic [3:0] run_len_r;

  // Ctrl writes in mid-run are refused, so they are left out here
  assign ctl_wr    = reg_wr && reg_addr == `AES_OFS_CTRL && !busy
                     && !trx_sleep;
  assign start_req = ctl_wr && reg_wdata[`AES_CTRL_REQ_BIT];

  // Shadow of the interrupt enable, cleared like the engine
  always_ff @(posedge core_clk)
  begin
    if (rst || trx_sleep)
      im_q <= 1'b0;
    else if (ctl_wr)
      im_q <= reg_wdata[`AES_CTRL_IM_BIT];
  end

  // Cycles that busy has stood so far; saturates so it cannot wrap
  always_ff @(posedge core_clk)
  begin
    if (rst || trx_sleep || !busy)
      run_len_r <= 4'h0;
    else if (run_len_r != 4'hF)
      run_len_r <= run_len_r + 4'h1;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_run_starts: assert property (start_req |=> busy)
    else $error("request did not start a run");
  a_start_cause: assert property ($rose(busy) |-> $past(start_req))
    else $error("run started without a request");
  // A sleep in mid-run ends the run early, so only quiet runs count
  a_run_length: assert property
    ($fell(busy) && !$past(trx_sleep) |-> run_len_r == RUN_LEN)
    else $error("run length is not ten cycles");
  a_rdata_idle: assert property
    (!$past(reg_rd) |-> reg_rdata == `AES_BYTE_ZERO)
    else $error("read data outside the answer cycle");
  a_sleep_clear: assert property
    (trx_sleep |=> !busy && !completion_irq && reg_rdata == 8'h00)
    else $error("sleep did not clear the engine");
  a_irq_masked: assert property
    (completion_irq |-> im_q || $past(im_q))
    else $error("interrupt raised while disabled");
  a_irq_raised: assert property
    ($fell(busy) && !$past(trx_sleep) && !trx_sleep && im_q
     |=> completion_irq)
    else $error("no interrupt after an enabled run");
  a_req_reads_zero: assert property
    (reg_rd && reg_addr == `AES_OFS_CTRL && !trx_sleep
     |=> !reg_rdata[`AES_CTRL_REQ_BIT])
    else $error("request bit read back as one");

  c_run_end: cover property ($fell(busy));
  c_irq: cover property (completion_irq);
  c_sleep: cover property (trx_sleep && !busy);
endmodule

bind aes_engine aes_engine_chk i_chk
(
  .core_clk       (core_clk),
  .rst            (rst),
  .trx_sleep      (trx_sleep),
  .reg_addr       (reg_addr),
  .reg_wdata      (reg_wdata),
  .reg_wr         (reg_wr),
  .reg_rd         (reg_rd),
  .reg_rdata      (reg_rdata),
  .busy           (busy),
  .completion_irq (completion_irq)
);

// ===== verif/tb_aes_engine.sv
// Self-checking bench for the AES-128 engine
`timescale 1ns/1ps
`include "aes_params.svh"

module tb_aes_engine;
  localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
  localparam logic [127:0] PTX = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] CTX = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  localparam logic [127:0] LRK = 128'h13111D7FE3944A17F307A78B4D2B30C5;

  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  logic         trx_sleep = 1'b0;
  logic [1:0]   reg_addr = 2'h0;
  logic [7:0]   reg_wdata = 8'h00;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [7:0]   reg_rdata;
  logic         busy;
  logic         completion_irq;
  logic [7:0]   byt;
  logic [127:0] blk;
  int           errors = 0;
  int           comparisons = 0;
  int           cycles = 0;

  aes_engine i_dut
  (
    .core_clk       (core_clk),
    .rst            (rst),
    .trx_sleep      (trx_sleep),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .busy           (busy),
    .completion_irq (completion_irq)
  );

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  // Hang guard; the full run needs far fewer cycles than this
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // First byte on the port is the top byte of the block
  task automatic load(input logic [1:0] a, input logic [127:0] b);
    for (int i = 0; i < 16; i++)
      wr(a, b[127 - 8 * i -: 8]);
  endtask

  task automatic fetch(input logic [1:0] a, output logic [127:0] b);
    for (int i = 0; i < 16; i++)
    begin
      rd(a, byt);
      b = {b[119:0], byt};
    end
  endtask

  // Start a run and count the cycles for which busy stands
  task automatic run(input logic [7:0] ctl);
    int n;
    n = 0;
    wr(`AES_OFS_CTRL, ctl | 8'h80);
    #1;
    while (busy === 1'b1 && n < 2000)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(n, 10);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_encrypt;
    load(`AES_OFS_KEY, KEY);
    load(`AES_OFS_STATE, PTX);
    run(8'h04);
    rd(`AES_OFS_STATUS, byt);
    chk(byt, 8'h01);
    chk(completion_irq, 1'b1);
    fetch(`AES_OFS_STATE, blk);
    chk(blk, CTX);
    rd(`AES_OFS_STATUS, byt);
    chk(byt, 8'h00);
    chk(completion_irq, 1'b0);
    fetch(`AES_OFS_KEY, blk);
    chk(blk, LRK);
    $display("encrypt test done");
  endtask

  // Key is not written again: the stored key must still be in use
  task automatic t_chain;
    load(`AES_OFS_STATE, CTX ^ PTX);
    run(8'h20);
    rd(`AES_OFS_STATUS, byt);
    chk(byt, 8'h01);
    chk(completion_irq, 1'b0);
    fetch(`AES_OFS_STATE, blk);
    chk(blk, CTX);
    $display("chain test done");
  endtask

  task automatic t_decrypt;
    load(`AES_OFS_KEY, LRK);
    load(`AES_OFS_STATE, CTX);
    run(8'h08);
    fetch(`AES_OFS_STATE, blk);
    chk(blk, PTX);
    $display("decrypt test done");
  endtask

  task automatic t_error;
    for (int i = 0; i < 5; i++)
      wr(`AES_OFS_STATE, 8'hA5);
    run(8'h04);
    @(posedge core_clk);
    #1 chk(completion_irq, 1'b1);
    rd(`AES_OFS_STATUS, byt);
    chk(byt, 8'h80);
    rd(`AES_OFS_STATUS, byt);
    chk(byt, 8'h00);
    // No access since the partial run: its start must have rewound
    run(8'h00);
    rd(`AES_OFS_STATUS, byt);
    chk(byt, 8'h01);
    run(8'h28);
    rd(`AES_OFS_STATUS, byt);
    chk(byt, 8'h80);
    $display("error test done");
  endtask

  task automatic t_sleep;
    wr(`AES_OFS_CTRL, 8'h24);
    rd(`AES_OFS_CTRL, byt);
    chk(byt, 8'h24);
    @(posedge core_clk);
    trx_sleep <= 1'b1;
    repeat (2) @(posedge core_clk);
    trx_sleep <= 1'b0;
    rd(`AES_OFS_CTRL, byt);
    chk(byt, 8'h00);
    fetch(`AES_OFS_KEY, blk);
    chk(blk, 128'h0);
    $display("sleep test done");
  endtask

  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_encrypt();
    t_chain();
    t_decrypt();
    t_error();
    t_sleep();
    end_sim();
  end
endmodule
